// ===== logic/fes_pkg.sv
// package: register map, field layout and port carriers of the flash erase-select block
//
// Contract
// - upper erase register clears on reset, standby, pin low
// - upper bit 0 held zero without write unlock
// - only the selected block may be erased
// - more than one select bit clears both registers
// - flash disabled: erase registers read zero, ignore writes
// - upper bits map the two 32-kbyte blocks
// - lower map: four 1k, 28k, 16k, two 8k
// - emulation register cleared only by power-on, hardware standby
// - emulation select protects all blocks from program/erase
// - emulation overlays ram window on chosen 1k block
// - area field ignored while emulation not selected
// - emulation bits 7..5 read zero; write 0 to 4,2
// - serial extension register clears on any reset, standby; the code clears it in hardware standby only, not in software standby
// - window bit maps flash control registers at ffffa8..ffffac
// - window bit clear deselects them, contents kept
// - write-allow bit mirrors the write-allow pin
// - write unlock settable only with pin high; gates erase selects
package fes_pkg;

   // register byte offsets on the bus
   localparam logic [7:0]  OFS_EBR_LO      = 8'h00;
   localparam logic [7:0]  OFS_EBR_UP      = 8'h04;
   localparam logic [7:0]  OFS_EMU         = 8'h08;
   localparam logic [7:0]  OFS_SCX         = 8'h0c;
   localparam logic [7:0]  OFS_MODE1       = 8'h10;

   // field positions
   localparam int unsigned EMU_SEL_BIT     = 3;
   localparam int unsigned WIN_EN_BIT      = 3;
   localparam int unsigned MODE1_PIN_BIT   = 7;
   localparam int unsigned MODE1_UNLK_BIT  = 6;
   localparam int unsigned EMU_AREA_SHIFT  = 10;

   // reset values
   localparam logic [7:0]  RST_EBR_LO      = 8'h00;
   localparam logic [1:0]  RST_EBR_UP      = 2'h0;
   localparam logic [4:0]  RST_EMU         = 5'h00;
   localparam logic [7:0]  RST_SCX         = 8'h00;

   // erase block start addresses, block 1..9; block 0 starts at address zero
   localparam logic [23:0] BLK1_BASE       = 24'h000400;
   localparam logic [23:0] BLK2_BASE       = 24'h000800;
   localparam logic [23:0] BLK3_BASE       = 24'h000c00;
   localparam logic [23:0] BLK4_BASE       = 24'h001000;
   localparam logic [23:0] BLK5_BASE       = 24'h008000;
   localparam logic [23:0] BLK6_BASE       = 24'h00c000;
   localparam logic [23:0] BLK7_BASE       = 24'h00e000;
   localparam logic [23:0] BLK8_BASE       = 24'h010000;
   localparam logic [23:0] BLK9_BASE       = 24'h018000;
   localparam logic [23:0] FLASH_END       = 24'h01ffff;
   localparam logic [3:0]  BLK_NONE        = 4'hf;

   // emulation ram window and flash control register window
   localparam logic [23:0] EMU_RAM_BASE    = 24'hffd000;
   localparam logic [23:0] FCTL_WIN_LO     = 24'hffffa8;
   localparam logic [23:0] FCTL_WIN_HI     = 24'hffffac;

   // same-clock control inputs
   typedef struct packed {
      logic flash_off;
      logic sw_standby;
      logic manual_reset;
   } fes_ctl_s;

   // program/erase permission outputs
   typedef struct packed {
      logic [9:0] erase_allow;
      logic       program_allow;
      logic       addr_erase_ok;
      logic       addr_prog_ok;
   } fes_pe_s;

   // emulation overlay and register window outputs
   typedef struct packed {
      logic        active;
      logic        remap_hit;
      logic [23:0] remap_addr;
      logic        fctl_sel;
   } fes_emu_s;

endpackage

// ===== logic/fes_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module fes_sync (
   // clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // pin side
   input  wire logic pin_in,
   // clock side
   output logic      level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } fes_sync_s;

   fes_sync_s s_q;
   fes_sync_s s_d;

   always_comb begin
      s_d    = s_q;
      s_d.s1 = pin_in;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      // a change counts only once stages two and three agree
      if (s_q.s2 == s_q.s3) begin
         s_d.lvl = s_q.s3;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign level = s_q.lvl;
endmodule

// ===== logic/fes_top.sv
// flash erase-select, ram emulation and register window logic behind ahb-lite
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module fes_top (
   // clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // ahb-lite slave
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic [31:0]           hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   // pins
   input  wire logic             flash_write_allow_pin,
   input  wire logic             hw_standby_pin,
   // same-clock system control
   input  wire fes_pkg::fes_ctl_s ctl,
   input  wire logic [23:0]      cpu_addr,
   // permissions and overlay
   output fes_pkg::fes_pe_s      pe,
   output fes_pkg::fes_emu_s     emu
);
   import fes_pkg::*;

   typedef struct packed {
      logic [7:0]  ebr_lo;
      logic [1:0]  ebr_up;
      logic [4:0]  emu_reg;
      logic [7:0]  scx;
      logic        unlock;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic        rd_pend;
      logic [7:0]  rd_addr;
      logic [31:0] hrdata;
      logic        hready;
      logic        hresp;
      fes_pe_s     pe;
      fes_emu_s    emu;
   } fes_state_s;

   fes_state_s s_q;
   fes_state_s s_d;
   logic       pin_ok;
   logic       hw_stby;

   fes_sync u_pin_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin_in  (flash_write_allow_pin),
      .level   (pin_ok)
   );

   fes_sync u_stby_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin_in  (hw_standby_pin),
      .level   (hw_stby)
   );

   // number of set select bits over both erase registers
   function automatic logic [3:0] sel_count(input logic [9:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 10; i++) begin
         n = n + {3'h0, v[i]};
      end
      return n;
   endfunction

   // erase block holding an address, none outside flash
   function automatic logic [3:0] block_of(input logic [23:0] a);
      logic [3:0] b;
      if (a > FLASH_END) begin
         b = BLK_NONE;
      end else if (a >= BLK9_BASE) begin
         b = 4'h9;
      end else if (a >= BLK8_BASE) begin
         b = 4'h8;
      end else if (a >= BLK7_BASE) begin
         b = 4'h7;
      end else if (a >= BLK6_BASE) begin
         b = 4'h6;
      end else if (a >= BLK5_BASE) begin
         b = 4'h5;
      end else if (a >= BLK4_BASE) begin
         b = 4'h4;
      end else if (a >= BLK3_BASE) begin
         b = 4'h3;
      end else if (a >= BLK2_BASE) begin
         b = 4'h2;
      end else if (a >= BLK1_BASE) begin
         b = 4'h1;
      end else begin
         b = 4'h0;
      end
      return b;
   endfunction

   // register read mux on current state
   function automatic logic [7:0] reg_read(input fes_state_s s, input logic [7:0] a,
                                           input logic win, input logic off,
                                           input logic pin);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         OFS_EBR_LO: begin
            if (win && !off) begin
               r = s.ebr_lo;
            end
         end
         OFS_EBR_UP: begin
            if (win && !off) begin
               r = {6'h00, s.ebr_up};
            end
         end
         OFS_EMU: begin
            r = {3'h0, s.emu_reg};
         end
         OFS_SCX: begin
            r = s.scx;
         end
         OFS_MODE1: begin
            if (win && !off) begin
               r[MODE1_PIN_BIT]  = pin;
               r[MODE1_UNLK_BIT] = s.unlock;
            end
         end
         default: begin
            r = 8'h00;
         end
      endcase
      return r;
   endfunction

   always_comb begin
      logic       win;
      logic       off;
      logic       stby;
      logic [7:0] wd;
      logic [9:0] sel;
      logic       prot;
      logic [3:0] blk;
      logic [23:0] ebase;
      win   = 1'b0;
      off   = 1'b0;
      stby  = 1'b0;
      wd    = 8'h00;
      sel   = 10'h000;
      prot  = 1'b0;
      blk   = 4'h0;
      ebase = 24'h000000;

      s_d     = s_q;
      win     = s_q.scx[WIN_EN_BIT];
      off     = ctl.flash_off;
      stby    = hw_stby | ctl.sw_standby;
      wd      = hwdata[7:0];
      s_d.wr_pend = 1'b0;
      s_d.hresp   = 1'b0;

      // data phase of a write
      if (s_q.wr_pend) begin
         case (s_q.wr_addr)
            OFS_EBR_LO, OFS_EBR_UP: begin
               // erase selects only with window open, flash on, unlock set
               if (win && !off && s_q.unlock) begin
                  sel = {s_q.ebr_up, s_q.ebr_lo};
                  if (s_q.wr_addr == OFS_EBR_LO) begin
                     sel[7:0] = wd;
                  end else begin
                     sel[9:8] = wd[1:0];
                  end
                  if (sel_count(sel) > 4'h1) begin
                     sel = 10'h000;
                  end
                  s_d.ebr_lo = sel[7:0];
                  s_d.ebr_up = sel[9:8];
               end
            end
            OFS_EMU: begin
               s_d.emu_reg = wd[4:0];
            end
            OFS_SCX: begin
               s_d.scx = wd;
            end
            OFS_MODE1: begin
               if (win && !off) begin
                  s_d.unlock = wd[MODE1_UNLK_BIT] & pin_ok;
               end
            end
            default: begin
               s_d.wr_pend = 1'b0;
            end
         endcase
      end

      // forced clears win over any write in the same cycle
      if (!pin_ok || stby || ctl.manual_reset) begin
         s_d.unlock = 1'b0;
      end
      if (!pin_ok || stby) begin
         s_d.ebr_lo = RST_EBR_LO;
         s_d.ebr_up = RST_EBR_UP;
      end
      if (!s_d.unlock) begin
         s_d.ebr_lo    = RST_EBR_LO;
         s_d.ebr_up[0] = 1'b0;
      end
      if (hw_stby) begin
         s_d.emu_reg = RST_EMU;
      end
      if (hw_stby || ctl.manual_reset) begin
         s_d.scx = RST_SCX;
      end

      // read answer one cycle after its address phase
      if (s_q.rd_pend) begin
         s_d.hrdata  = {24'h000000, reg_read(s_q, s_q.rd_addr, win, off, pin_ok)};
         s_d.hready  = 1'b1;
         s_d.rd_pend = 1'b0;
      end

      // address phase; reads take one wait state so a prior write lands first
      if (hsel && hready && htrans[1]) begin
         if (hwrite) begin
            s_d.wr_pend = 1'b1;
            s_d.wr_addr = haddr[7:0];
         end else begin
            s_d.rd_pend = 1'b1;
            s_d.rd_addr = haddr[7:0];
            s_d.hready  = 1'b0;
         end
      end

      // permissions follow the new register values
      prot = s_d.emu_reg[EMU_SEL_BIT] | !pin_ok | !s_d.unlock | off;
      sel  = {s_d.ebr_up, s_d.ebr_lo};
      s_d.pe.erase_allow   = prot ? 10'h000 : sel;
      s_d.pe.program_allow = !prot;
      blk = block_of(cpu_addr);
      s_d.pe.addr_erase_ok = (blk != BLK_NONE) && !prot && sel[blk];
      s_d.pe.addr_prog_ok  = (blk != BLK_NONE) && !prot;

      // overlay: area only counts with emulation selected
      s_d.emu.active = s_d.emu_reg[EMU_SEL_BIT];
      ebase = {12'h000, s_d.emu_reg[1:0], 10'h000};
      s_d.emu.remap_hit = s_d.emu.active
                          && (cpu_addr[23:EMU_AREA_SHIFT] == ebase[23:EMU_AREA_SHIFT]);
      s_d.emu.remap_addr = s_d.emu.remap_hit
                           ? (EMU_RAM_BASE | {14'h0000, cpu_addr[9:0]})
                           : cpu_addr;
      s_d.emu.fctl_sel = s_d.scx[WIN_EN_BIT]
                         && (cpu_addr >= FCTL_WIN_LO) && (cpu_addr <= FCTL_WIN_HI);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q        <= '0;
         s_q.hready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign hrdata    = s_q.hrdata;
   assign hreadyout = s_q.hready;
   assign hresp     = s_q.hresp;
   assign pe        = s_q.pe;
   assign emu       = s_q.emu;
endmodule

// ===== verification/fes_checker.sv
// port assertions for the flash erase-select block
`timescale 1ns/100ps
module fes_checker
   import fes_pkg::*;
(
   // clock and reset
   input wire logic              hclk,
   input wire logic              hresetn,
   // bus
   input wire logic              hsel,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic              hready,
   input wire logic [31:0]       hrdata,
   input wire logic              hreadyout,
   input wire logic              hresp,
   // pins and results
   input wire logic              flash_write_allow_pin,
   input wire fes_pkg::fes_ctl_s ctl,
   input wire logic [23:0]       cpu_addr,
   input wire fes_pkg::fes_pe_s  pe,
   input wire fes_pkg::fes_emu_s emu
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence rd_req;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   sequence rd_ans;
      !hreadyout ##1 hreadyout;
   endsequence
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_read_wait: assert property (rd_req |=> rd_ans)
      else $error("read wait cycle wrong");
   a_write_nowait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
      else $error("write stalled");
   a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_one_select: assert property ($onehot0(pe.erase_allow))
      else $error("several blocks erasable");
   a_emu_protect: assert property (emu.active |-> pe.erase_allow == 10'h0 && !pe.program_allow)
      else $error("emulation left flash unprotected");
   a_pin_low: assert property (!flash_write_allow_pin [*8] |-> pe.erase_allow == 10'h0)
      else $error("erase allowed with pin low");
   a_flash_off: assert property (ctl.flash_off |=> !pe.program_allow && pe.erase_allow == 10'h0)
      else $error("disabled flash unprotected");
   a_remap_addr: assert property (emu.remap_hit |-> emu.remap_addr == (EMU_RAM_BASE | {14'h0, $past(cpu_addr[9:0])}))
      else $error("remap address wrong");
   a_area_ignored: assert property (!emu.active && !$past(emu.active) |-> !emu.remap_hit)
      else $error("remap without emulation");
   a_window_sel: assert property (emu.fctl_sel |-> $past(cpu_addr) inside {[FCTL_WIN_LO:FCTL_WIN_HI]})
      else $error("register window outside range");
endmodule

// ===== verification/fes_cpu_model.sv
// ahb-lite master standing in for the cpu core
`timescale 1ns/100ps
module fes_cpu_model (
   // clock and bus answer
   input wire logic        hclk,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   // bus request
   output logic            hsel,
   output logic [31:0]     haddr,
   output logic [1:0]      htrans,
   output logic            hwrite,
   output logic [2:0]      hsize,
   output logic [31:0]     hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // called right after a rising edge; returns at the edge that ends the data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output bit ok);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do begin
         @(posedge hclk);
         n++;
      end while (!hready && n < 64);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do begin
         @(posedge hclk);
         n++;
      end while (!hready && n < 128);
      q = hrdata[7:0];
      ok = hready;
   endtask
endmodule

// ===== verification/fes_top_bench.sv
// self-checking bench for the flash erase-select block
`timescale 1ns/100ps
module fes_top_bench;
   import fes_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pin, hws;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [23:0] cpu_addr;
   logic [7:0]  q;
   bit          ok;
   fes_ctl_s    ctl;
   fes_pe_s     pe;
   fes_emu_s    emu;
   int          failures, total_checks, lo, up, em, sx, un, seed;
   logic [23:0] base [10] = '{24'h0, BLK1_BASE, BLK2_BASE, BLK3_BASE, BLK4_BASE,
                              BLK5_BASE, BLK6_BASE, BLK7_BASE, BLK8_BASE, BLK9_BASE};
   logic [23:0] wa [4] = '{FCTL_WIN_LO - 24'h1, FCTL_WIN_LO, FCTL_WIN_HI, FCTL_WIN_HI + 24'h1};
   fes_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .flash_write_allow_pin(pin),
      .hw_standby_pin(hws), .ctl, .cpu_addr, .pe, .emu);
   fes_cpu_model cpu_u (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata);
   function automatic logic [9:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[9:0];
   endfunction
   function automatic bit win();
      return sx[3] && !ctl.flash_off;
   endfunction
   function automatic logic [7:0] ex(int a);
      case (a)
         0: return win() ? 8'(lo) : 8'h00;
         4: return win() ? 8'(up) : 8'h00;
         8: return 8'(em);
         12: return 8'(sx);
         16: return win() ? {pin, un[0], 6'h00} : 8'h00;
         default: return 8'h00;
      endcase
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic clr(input bit hw);
      lo = 0;
      up = 0;
      un = 0;
      if (hw) begin
         em = 0;
         sx = 0;
      end
   endtask
   // one bus transfer; reads compared with the model, writes applied to it
   task automatic acc(input bit w, input int a, input int d);
      cpu_u.xfer(w, 8'(a), 8'(d), q, ok);
      if (!ok) begin
         failures++;
         test_done();
      end
      if (!w)
         chk("read data", 32'(ex(a)), {24'h0, q});
      else if (a == 8)
         em = d & 'h1f;
      else if (a == 12)
         sx = d;
      else if (a == 16 && win())
         un = (pin && d[6]) ? 1 : 0;
      else if (a < 8 && win() && un == 1) begin
         if (a == 0)
            lo = d;
         else
            up = d & 3;
         if ($countones({up[1:0], lo[7:0]}) > 1) begin
            lo = 0;
            up = 0;
         end
      end
   endtask
   task automatic pec();
      bit pa;
      tick(2);
      pa = em[3] == 0 && pin && un == 1 && !ctl.flash_off;
      chk("erase allow", pa ? 32'({up[1:0], lo[7:0]}) : 32'h0, 32'(pe.erase_allow));
      chk("program allow", 32'(pa), 32'(pe.program_allow));
   endtask
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   initial begin
      tick(90000);
      failures++;
      test_done();
   end
   initial begin
      {hresetn, hws, pin, ctl, cpu_addr} = '0;
      pin = 1'b1;
      seed = 32'h34de;
      clr(1);
      tick(16);
      hresetn <= 1'b1;
      tick(8);
      for (int a = 0; a <= 32; a += 4) acc(0, a, 0);
      acc(1, 12, 8);
      for (int a = 0; a <= 32; a += 4) acc(0, a, 0);
      $display("reset and window test done");
      acc(1, 4, 1);
      acc(0, 4, 0);
      acc(1, 16, 'h40);
      acc(0, 16, 0);
      for (int i = 0; i < 10; i++) begin
         acc(1, i < 8 ? 4 : 0, 0);
         acc(1, i < 8 ? 0 : 4, 1 << (i % 8));
         cpu_addr <= base[i];
         pec();
         chk("block erase ok", 32'h1, 32'(pe.addr_erase_ok));
         chk("block prog ok", 32'h1, 32'(pe.addr_prog_ok));
         cpu_addr <= base[(i + 1) % 10];
         tick(2);
         chk("other block erase ok", 32'h0, 32'(pe.addr_erase_ok));
      end
      acc(1, 0, 1);
      acc(0, 0, 0);
      acc(0, 4, 0);
      pec();
      $display("erase select test done");
      acc(1, 4, 1);
      for (int r = 0; r < 4; r++) begin
         acc(1, 8, 'he8 | r);
         acc(0, 8, 0);
         pec();
         cpu_addr <= base[r] | 24'(xs());
         tick(2);
         chk("remap hit", 32'h1, 32'(emu.remap_hit));
         chk("emulation active", 32'h1, 32'(emu.active));
         chk("remap addr", 32'(EMU_RAM_BASE | 24'(cpu_addr[9:0])), 32'(emu.remap_addr));
      end
      acc(1, 8, 3);
      cpu_addr <= base[3];
      pec();
      chk("remap addr", 32'(base[3]), 32'(emu.remap_addr));
      for (int k = 0; k < 4; k++) begin
         cpu_addr <= wa[k];
         tick(2);
         chk("window select", 32'(k == 1 || k == 2), 32'(emu.fctl_sel));
      end
      acc(1, 12, 0);
      acc(0, 4, 0);
      cpu_addr <= FCTL_WIN_LO;
      tick(2);
      chk("window select", 32'h0, 32'(emu.fctl_sel));
      acc(1, 12, 8);
      acc(0, 4, 0);
      $display("emulation and window test done");
      ctl.flash_off <= 1'b1;
      acc(0, 4, 0);
      acc(1, 4, 2);
      pec();
      ctl.flash_off <= 1'b0;
      acc(0, 4, 0);
      acc(1, 8, 9);
      ctl.sw_standby <= 1'b1;
      tick(2);
      ctl.sw_standby <= 1'b0;
      clr(0);
      acc(0, 4, 0);
      acc(0, 8, 0);
      pin <= 1'b0;
      tick(10);
      acc(1, 16, 'h40);
      acc(0, 16, 0);
      pin <= 1'b1;
      tick(10);
      ctl.manual_reset <= 1'b1;
      tick(1);
      ctl.manual_reset <= 1'b0;
      clr(0);
      sx = 0;
      acc(0, 8, 0);
      acc(0, 12, 0);
      acc(1, 12, 8);
      hws <= 1'b1;
      tick(10);
      hws <= 1'b0;
      tick(10);
      clr(1);
      acc(0, 8, 0);
      acc(0, 12, 0);
      $display("standby and pin test done");
      test_done();
   end
endmodule
bind fes_top fes_checker chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata,
   .hreadyout, .hresp, .flash_write_allow_pin, .ctl, .cpu_addr, .pe, .emu);
